/* File: rtl/ucdr_pkg.sv */
package ucdr_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses on the AXI4-Lite slave)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_CFG = 12'h004;
    localparam logic [11:0] REG_TAIL_LEN = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00c;
    localparam logic [11:0] TAIL_BASE = 12'h100;
    localparam int TAIL_WORDS = 64;

    // Control and configuration field positions
    localparam int CTRL_SELF_PWR = 0;
    localparam int CTRL_WAKE = 1;
    localparam int CTRL_BUS_RUN = 2;
    localparam int CFG_VAL_LSB = 0;
    localparam int CFG_STR_LSB = 8;
    localparam int CFG_NIF_LSB = 16;
    localparam int CFG_PWR_LSB = 24;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] CFG_VAL_RESET = 8'h01;
    localparam logic [7:0] NIF_RESET = 8'h01;

    // ----------------------------------------------------------------
    // Configuration descriptor layout
    // ----------------------------------------------------------------
    localparam logic [15:0] CFG_HDR_LEN = 16'h0009;
    localparam logic [7:0] DESC_TYPE_CFG = 8'h02;
    localparam logic [15:0] OFS_LEN = 16'h0000;
    localparam logic [15:0] OFS_TYPE = 16'h0001;
    localparam logic [15:0] OFS_TOTAL_LO = 16'h0002;
    localparam logic [15:0] OFS_TOTAL_HI = 16'h0003;
    localparam logic [15:0] OFS_NIF = 16'h0004;
    localparam logic [15:0] OFS_VAL = 16'h0005;
    localparam logic [15:0] OFS_STR = 16'h0006;
    localparam logic [15:0] OFS_ATTR = 16'h0007;
    localparam logic [15:0] OFS_PWR = 16'h0008;
    localparam logic [4:0] ATTR_RSVD = 5'h00;
    localparam logic [7:0] POWER_UNIT_MA = 8'h02;
    localparam logic [7:0] MIN_BUS_PWR = 8'h01;

    // ----------------------------------------------------------------
    // Standard request codes from the request decoder
    // ----------------------------------------------------------------
    localparam logic [2:0] REQ_GET_DESC = 3'h0;
    localparam logic [2:0] REQ_SET_CFG = 3'h1;
    localparam logic [2:0] REQ_GET_CFG = 3'h2;
    localparam logic [2:0] REQ_GET_STATUS = 3'h3;
    localparam logic [2:0] REQ_SET_IF = 3'h4;
    localparam logic [2:0] REQ_GET_IF = 3'h5;
    localparam logic [15:0] LEN_STATUS = 16'h0002;
    localparam logic [15:0] LEN_ONE = 16'h0001;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SEND = 3'h2,
        ST_DONE = 3'h4
    } ucdr_state_e;

endpackage

/* File: rtl/ucdr_desc_if.sv */
`timescale 1ns/1ps
// Descriptor byte lookup and tail memory write path
interface ucdr_desc_if #(parameter int WORD_W = 6);
    logic [15:0] idx;
    logic [7:0] data;
    logic [15:0] total_len;
    logic [7:0] num_if;
    logic [7:0] cfg_val;
    logic [7:0] str_idx;
    logic [7:0] attr;
    logic [7:0] max_pwr;
    logic wr_en;
    logic [WORD_W-1:0] wr_word;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    modport host (output idx, total_len, num_if, cfg_val, str_idx, attr,
        max_pwr, wr_en, wr_word, wr_data, wr_strb, input data);
    modport store (input idx, total_len, num_if, cfg_val, str_idx, attr,
        max_pwr, wr_en, wr_word, wr_data, wr_strb, output data);
endinterface

/* File: rtl/ucdr_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for a level from a pin
module ucdr_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

/* File: rtl/ucdr_desc.sv */
`timescale 1ns/1ps
// Builds the configuration descriptor byte stream: fixed header from the
// live settings, then the interface and endpoint descriptors in memory
module ucdr_desc import ucdr_pkg::*; #(
    parameter int DEPTH = TAIL_WORDS
) (
    input wire logic clk_i,
    ucdr_desc_if.store d
);
    localparam int BW = $clog2(DEPTH) + 2;
    localparam logic [15:0] TAIL_BYTES = 16'(4 * DEPTH);

    logic [7:0] mem [0:4*DEPTH-1];
    logic [15:0] tail_idx;
    logic [7:0] tail_byte;

    // Tail memory, written a word at a time with byte strobes
    always_ff @(posedge clk_i) begin
        for (int b = 0; b < 4; b++) begin
            if (d.wr_en && d.wr_strb[b]) begin
                mem[{d.wr_word, 2'(b)}] <= d.wr_data[8*b +: 8];
            end
        end
    end

    // Header fields first, little-endian total length, then the tail
    assign tail_idx = d.idx - CFG_HDR_LEN;
    assign tail_byte = (tail_idx < TAIL_BYTES) ? mem[tail_idx[BW-1:0]]
                                               : 8'h00;
    assign d.data = (d.idx == OFS_LEN) ? CFG_HDR_LEN[7:0] :
        (d.idx == OFS_TYPE) ? DESC_TYPE_CFG :
        (d.idx == OFS_TOTAL_LO) ? d.total_len[7:0] :
        (d.idx == OFS_TOTAL_HI) ? d.total_len[15:8] :
        (d.idx == OFS_NIF) ? d.num_if :
        (d.idx == OFS_VAL) ? d.cfg_val :
        (d.idx == OFS_STR) ? d.str_idx :
        (d.idx == OFS_ATTR) ? d.attr :
        (d.idx == OFS_PWR) ? d.max_pwr :
        tail_byte;
endmodule

/* File: rtl/ucdr_top.sv */
`timescale 1ns/1ps
module ucdr_top import ucdr_pkg::*; #(
    parameter int NUM_IF = 4,
    parameter int DEPTH = TAIL_WORDS,
    parameter logic [9:0] UNCFG_MA = 10'h064
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic EXT_PWR_I,
    input wire logic REQ_VALID_I,
    output logic REQ_READY_O,
    input wire logic [2:0] REQ_CODE_I,
    input wire logic [15:0] REQ_VALUE_I,
    input wire logic [15:0] REQ_INDEX_I,
    input wire logic [15:0] REQ_LENGTH_I,
    output logic TX_VALID_O,
    input wire logic TX_READY_I,
    output logic [7:0] TX_DATA_O,
    output logic TX_LAST_O,
    output logic DONE_O,
    output logic STALL_O,
    output logic CONFIGURED_O,
    output logic [7:0] CONFIG_VALUE_O,
    output logic LOW_POWER_O,
    output logic [9:0] BUS_LIMIT_MA_O,
    output logic OPS_FAIL_O
);
    localparam int WORD_W = $clog2(DEPTH);
    localparam logic [15:0] TAIL_BYTES = 16'(4 * DEPTH);
    localparam logic [ADDR_W-1:0] TAIL_END = ADDR_W'(TAIL_BASE + 4 * DEPTH);

    // Smaller of two byte counts
    function automatic logic [15:0] lower16(input logic [15:0] a,
                                            input logic [15:0] b);
        lower16 = (a < b) ? a : b;
    endfunction

    ucdr_desc_if #(.WORD_W(WORD_W)) dif ();

    ucdr_state_e state;
    logic [2:0] ctrl;
    logic [7:0] cfg_val, str_idx, num_if, max_pwr, active_cfg;
    logic [15:0] tail_len, cnt, send_len;
    logic [15:0] reply_q;
    logic src_desc, stall_pend, ext_pwr;
    logic [7:0] alt [0:NUM_IF-1];
    logic aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // ----------------------------------------------------------------
    // Power source monitoring
    // ----------------------------------------------------------------
    ucdr_sync u_pwr_sync (
        .clk_i(CLK_I),
        .rst_n_i(RSTN_I),
        .d_i(EXT_PWR_I),
        .q_o(ext_pwr)
    );

    // Self-powered status follows the supply; loss may disable functions
    logic self_now, low_power, ops_fail;
    assign self_now = ctrl[CTRL_SELF_PWR] & ext_pwr;
    assign low_power = ctrl[CTRL_SELF_PWR] & ~ext_pwr;
    assign ops_fail = low_power & ~ctrl[CTRL_BUS_RUN];

    // Descriptor fields derived from the settings
    logic [7:0] attr, eff_pwr;
    logic [15:0] total_len;
    assign eff_pwr = (ctrl[CTRL_SELF_PWR] && max_pwr == 8'h00)
                     ? MIN_BUS_PWR : max_pwr;
    assign attr = {1'b1,
                   ctrl[CTRL_SELF_PWR],
                   ctrl[CTRL_WAKE],
                   ATTR_RSVD};
    assign total_len = CFG_HDR_LEN + lower16(tail_len, TAIL_BYTES);

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    logic idle, accept, if_ok, is_desc, set_cfg_ok, set_if_ok, get_if_ok;
    logic get_cfg, get_sts, req_bad;
    logic [7:0] req_val, if_num;
    logic [15:0] avail, len_next, reply_next;
    assign idle = (state == ST_IDLE);
    assign REQ_READY_O = idle;
    assign accept = REQ_VALID_I & idle;
    assign req_val = REQ_VALUE_I[7:0];
    assign if_num = REQ_INDEX_I[7:0];
    assign if_ok = CONFIGURED_O && if_num < num_if && 32'(if_num) < NUM_IF;
    assign is_desc = REQ_CODE_I == REQ_GET_DESC
                     && REQ_VALUE_I[15:8] == DESC_TYPE_CFG
                     && req_val == 8'h00;
    assign set_cfg_ok = REQ_CODE_I == REQ_SET_CFG
                        && (req_val == 8'h00
                            || (req_val == cfg_val && !ops_fail));
    assign set_if_ok = REQ_CODE_I == REQ_SET_IF && if_ok && !ops_fail;
    assign get_if_ok = REQ_CODE_I == REQ_GET_IF && if_ok;
    assign get_cfg = REQ_CODE_I == REQ_GET_CFG;
    assign get_sts = REQ_CODE_I == REQ_GET_STATUS;
    assign req_bad = ~(is_desc | set_cfg_ok | set_if_ok | get_if_ok
                       | get_cfg | get_sts);
    assign avail = is_desc ? total_len :
                   get_sts ? LEN_STATUS :
                   (get_cfg | get_if_ok) ? LEN_ONE : 16'h0000;
    assign len_next = lower16(REQ_LENGTH_I, avail);
    assign reply_next = get_sts ? {15'h0000, self_now} :
                        get_cfg ? {8'h00, active_cfg} :
                        {8'h00, alt[if_num[$clog2(NUM_IF)-1:0]]};

    // Byte selection for the stream, descriptor or short reply
    logic [15:0] look_idx, reply_now;
    logic use_desc, tx_take, at_last;
    logic [7:0] next_byte;
    assign look_idx = idle ? 16'h0000 : cnt + 16'h0001;
    assign use_desc = idle ? is_desc : src_desc;
    assign reply_now = idle ? reply_next : reply_q;
    assign dif.idx = look_idx;
    assign next_byte = use_desc ? dif.data :
                       look_idx[0] ? reply_now[15:8] : reply_now[7:0];
    assign tx_take = TX_VALID_O & TX_READY_I;
    assign at_last = (cnt + 16'h0002 == send_len);

    // ----------------------------------------------------------------
    // Transfer state machine
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state <= ST_IDLE;
            cnt <= 16'h0000;
            send_len <= 16'h0000;
            reply_q <= 16'h0000;
            src_desc <= 1'b0;
            stall_pend <= 1'b0;
            TX_VALID_O <= 1'b0;
            TX_DATA_O <= 8'h00;
            TX_LAST_O <= 1'b0;
            DONE_O <= 1'b0;
            STALL_O <= 1'b0;
        end else begin
            DONE_O <= 1'b0;
            STALL_O <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        cnt <= 16'h0000;
                        send_len <= len_next;
                        reply_q <= reply_next;
                        src_desc <= is_desc;
                        stall_pend <= req_bad;
                        TX_DATA_O <= next_byte;
                        TX_LAST_O <= (len_next == LEN_ONE);
                        if (!req_bad && len_next != 16'h0000) begin
                            TX_VALID_O <= 1'b1;
                            state <= ST_SEND;
                        end else begin
                            state <= ST_DONE;
                        end
                    end
                end
                ST_SEND: begin
                    if (tx_take && TX_LAST_O) begin
                        TX_VALID_O <= 1'b0;
                        state <= ST_DONE;
                    end else if (tx_take) begin
                        cnt <= cnt + 16'h0001;
                        TX_DATA_O <= next_byte;
                        TX_LAST_O <= at_last;
                    end
                end
                ST_DONE: begin
                    DONE_O <= ~stall_pend;
                    STALL_O <= stall_pend;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Configuration and alternate-setting state
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            CONFIGURED_O <= 1'b0;
            active_cfg <= 8'h00;
            for (int i = 0; i < NUM_IF; i++) begin
                alt[i] <= 8'h00;
            end
        end else if (accept && set_cfg_ok) begin
            CONFIGURED_O <= (req_val != 8'h00);
            active_cfg <= req_val;
            for (int i = 0; i < NUM_IF; i++) begin
                alt[i] <= 8'h00;
            end
        end else if (accept && set_if_ok) begin
            alt[if_num[$clog2(NUM_IF)-1:0]] <= req_val;
        end
    end

    // Power reporting toward the function logic
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            LOW_POWER_O <= 1'b0;
            OPS_FAIL_O <= 1'b0;
            BUS_LIMIT_MA_O <= UNCFG_MA;
        end else begin
            LOW_POWER_O <= low_power;
            OPS_FAIL_O <= ops_fail;
            BUS_LIMIT_MA_O <= CONFIGURED_O
                ? 10'(eff_pwr) * 10'(POWER_UNIT_MA) : UNCFG_MA;
        end
    end
    assign CONFIG_VALUE_O = active_cfg;

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    logic do_write, w_ctrl, w_cfg, w_tlen, w_tail, w_hit;
    logic [ADDR_W-1:0] wa, ra;
    assign S_AXI_AWREADY_O = ~aw_held;
    assign S_AXI_WREADY_O = ~w_held;
    assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;
    assign do_write = aw_held & w_held & ~S_AXI_BVALID_O;
    assign wa = {aw_addr[ADDR_W-1:2], 2'b00};
    assign w_ctrl = (wa == REG_CTRL);
    assign w_cfg = (wa == REG_CFG);
    assign w_tlen = (wa == REG_TAIL_LEN);
    assign w_tail = (wa >= TAIL_BASE) && (wa < TAIL_END);
    assign w_hit = w_ctrl | w_cfg | w_tlen | w_tail;

    // Tail memory holds interface and endpoint descriptors in order
    assign dif.wr_en = do_write & w_tail;
    assign dif.wr_word = WORD_W'((wa - TAIL_BASE) >> 2);
    assign dif.wr_data = w_data;
    assign dif.wr_strb = w_strb;
    assign dif.total_len = total_len;
    assign dif.num_if = num_if;
    assign dif.cfg_val = cfg_val;
    assign dif.str_idx = str_idx;
    assign dif.attr = attr;
    assign dif.max_pwr = eff_pwr;

    // Address and data may arrive in either order
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID_I && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && !w_held) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA_I;
                w_strb <= S_AXI_WSTRB_I;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= w_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    // Writable settings, each byte lane under its strobe
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl <= CTRL_RESET;
            cfg_val <= CFG_VAL_RESET;
            str_idx <= 8'h00;
            num_if <= NIF_RESET;
            max_pwr <= 8'h00;
            tail_len <= 16'h0000;
        end else if (do_write) begin
            if (w_ctrl && w_strb[0]) ctrl <= w_data[2:0];
            if (w_cfg && w_strb[0]) cfg_val <= w_data[CFG_VAL_LSB +: 8];
            if (w_cfg && w_strb[1]) str_idx <= w_data[CFG_STR_LSB +: 8];
            if (w_cfg && w_strb[2]) num_if <= w_data[CFG_NIF_LSB +: 8];
            if (w_cfg && w_strb[3]) max_pwr <= w_data[CFG_PWR_LSB +: 8];
            if (w_tlen && w_strb[0]) tail_len[7:0] <= w_data[7:0];
            if (w_tlen && w_strb[1]) tail_len[15:8] <= w_data[15:8];
        end
    end

    // Read decode; the tail window is write-only and reads as zero
    logic [31:0] rd_word;
    logic rd_hit;
    assign ra = {S_AXI_ARADDR_I[ADDR_W-1:2], 2'b00};
    assign rd_word = (ra == REG_CTRL) ? {29'h0, ctrl} :
        (ra == REG_CFG) ? {max_pwr, num_if, str_idx, cfg_val} :
        (ra == REG_TAIL_LEN) ? {16'h0000, tail_len} :
        (ra == REG_STATUS) ? {16'h0000, active_cfg, 4'h0, ops_fail,
                              CONFIGURED_O, self_now, ext_pwr} :
        32'h0000_0000;
    assign rd_hit = (ra == REG_CTRL) || (ra == REG_CFG)
                    || (ra == REG_TAIL_LEN) || (ra == REG_STATUS)
                    || ((ra >= TAIL_BASE) && (ra < TAIL_END));

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h0000_0000;
            S_AXI_RRESP_O <= RESP_OKAY;
        end else if (S_AXI_ARVALID_I && !S_AXI_RVALID_O) begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O <= rd_word;
            S_AXI_RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
        end
    end

    ucdr_desc #(.DEPTH(DEPTH)) u_desc (
        .clk_i(CLK_I),
        .d(dif.store)
    );
endmodule

/* File: tb/ucdr_checker.sv */
`timescale 1ns/1ps
// Port-level checks on the request, descriptor stream and power reporting side
module ucdr_checker import ucdr_pkg::*; #(
    parameter logic [9:0] UNCFG_MA = 10'h064
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic REQ_VALID_I,
    input wire logic REQ_READY_O,
    input wire logic [2:0] REQ_CODE_I,
    input wire logic TX_VALID_O,
    input wire logic TX_READY_I,
    input wire logic [7:0] TX_DATA_O,
    input wire logic TX_LAST_O,
    input wire logic DONE_O,
    input wire logic STALL_O,
    input wire logic CONFIGURED_O,
    input wire logic LOW_POWER_O,
    input wire logic [9:0] BUS_LIMIT_MA_O,
    input wire logic OPS_FAIL_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // Request side and stream timing
    a_resp_excl: assert property (!(DONE_O && STALL_O))
        else $error("done and stall at once");
    a_tx_hold: assert property (TX_VALID_O && !TX_READY_I |=>
        TX_VALID_O && $stable(TX_DATA_O) && $stable(TX_LAST_O))
        else $error("stream byte changed while stalled");
    a_tx_end: assert property (TX_VALID_O && TX_READY_I && TX_LAST_O
        |=> !TX_VALID_O ##1 DONE_O) else $error("no done after last");
    a_req_busy: assert property (REQ_VALID_I && REQ_READY_O
        |=> !REQ_READY_O) else $error("second request taken");
    a_setcfg_time: assert property (REQ_VALID_I && REQ_READY_O &&
        REQ_CODE_I == REQ_SET_CFG |-> ##2 (DONE_O || STALL_O))
        else $error("set configuration not answered");
    a_cfg_done: assert property ($rose(CONFIGURED_O) |->
        ##[0:2] DONE_O) else $error("configured without request");
    // Power bookkeeping
    a_limit_idle: assert property ((!CONFIGURED_O)[*2] |->
        BUS_LIMIT_MA_O == UNCFG_MA) else $error("bad idle limit");
    a_fail_cause: assert property (OPS_FAIL_O |->
        LOW_POWER_O || $past(LOW_POWER_O)) else $error("fail w/o loss");
endmodule

/* File: tb/ucdr_host.sv */
`timescale 1ns/1ps
// Host receive side: takes stream bytes, stalls every other cycle if slow
module ucdr_host (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic slow_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    output logic [7:0] rx [0:79],
    output int n_rx
);
    initial tx_ready_o = 1'h1;
    // Byte capture with optional back-pressure
    always @(posedge clk_i) begin
        if (clr_i) n_rx <= 0;
        else if (tx_valid_i && tx_ready_o) begin
            rx[n_rx] <= tx_data_i;
            n_rx <= n_rx + 1;
        end
        tx_ready_o <= slow_i ? !tx_ready_o : 1'h1;
    end
endmodule

/* File: tb/tb_usb_config_descriptor_responder.sv */
`timescale 1ns/1ps
module tb_usb_config_descriptor_responder import ucdr_pkg::*;;
    logic CLK_I = 1'h0, RSTN_I = 1'h0, EXT_PWR_I = 1'h1, clr = 1'h0;
    logic slow = 1'h1, S_AXI_AWVALID_I = 1'h0, S_AXI_WVALID_I = 1'h0;
    logic S_AXI_BREADY_I = 1'h0, S_AXI_ARVALID_I = 1'h0;
    logic S_AXI_RREADY_I = 1'h0, REQ_VALID_I = 1'h0, TX_READY_I;
    logic [11:0] S_AXI_AWADDR_I = '0, S_AXI_ARADDR_I = '0;
    logic [31:0] S_AXI_WDATA_I = '0, S_AXI_RDATA_O, d;
    logic [3:0] S_AXI_WSTRB_I = 4'hf;
    logic [2:0] REQ_CODE_I = '0;
    logic [15:0] REQ_VALUE_I = '0, REQ_INDEX_I = '0, REQ_LENGTH_I = '0;
    logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
    logic S_AXI_RVALID_O, REQ_READY_O, TX_VALID_O, TX_LAST_O, DONE_O;
    logic STALL_O, CONFIGURED_O, LOW_POWER_O, OPS_FAIL_O;
    logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, r;
    logic [7:0] TX_DATA_O, CONFIG_VALUE_O, rx [0:79], e [0:12];
    logic [9:0] BUS_LIMIT_MA_O;
    int n_rx, k, n_fail = 0, checks = 0;
    always #10 CLK_I = ~CLK_I;
    ucdr_top DUT (.CLK_I, .RSTN_I, .S_AXI_AWADDR_I, .S_AXI_AWVALID_I,
        .S_AXI_AWREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I, .S_AXI_WVALID_I,
        .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
        .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O,
        .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .EXT_PWR_I,
        .REQ_VALID_I, .REQ_READY_O, .REQ_CODE_I, .REQ_VALUE_I, .REQ_INDEX_I,
        .REQ_LENGTH_I, .TX_VALID_O, .TX_READY_I, .TX_DATA_O, .TX_LAST_O,
        .DONE_O, .STALL_O, .CONFIGURED_O, .CONFIG_VALUE_O, .LOW_POWER_O,
        .BUS_LIMIT_MA_O, .OPS_FAIL_O);
    ucdr_host host (.clk_i(CLK_I), .clr_i(clr), .slow_i(slow),
        .tx_valid_i(TX_VALID_O), .tx_data_i(TX_DATA_O),
        .tx_ready_o(TX_READY_I), .rx(rx), .n_rx(n_rx));
    task automatic final_report;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, x);
        checks++;
        if (g !== x) begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic tmo(input int i);
        if (i >= 400) begin
            n_fail++;
            final_report();
        end
    endtask
    // AXI4-Lite write: address and data together, wait for response
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        int i;
        logic ta, tw, tb;
        @(posedge CLK_I);
        S_AXI_AWADDR_I <= a;
        S_AXI_WDATA_I <= v;
        S_AXI_AWVALID_I <= 1'h1;
        S_AXI_WVALID_I <= 1'h1;
        S_AXI_BREADY_I <= 1'h1;
        for (i = 0; i < 400; i++) begin
            @(negedge CLK_I);
            ta = S_AXI_AWVALID_I && S_AXI_AWREADY_O === 1'h1;
            tw = S_AXI_WVALID_I && S_AXI_WREADY_O === 1'h1;
            tb = S_AXI_BVALID_O === 1'h1;
            r = S_AXI_BRESP_O;
            @(posedge CLK_I);
            if (ta) S_AXI_AWVALID_I <= 1'h0;
            if (tw) S_AXI_WVALID_I <= 1'h0;
            if (tb) break;
        end
        S_AXI_BREADY_I <= 1'h0;
        tmo(i);
    endtask
    // AXI4-Lite read
    task automatic rd(input logic [11:0] a);
        int i;
        logic ta, tv;
        @(posedge CLK_I);
        S_AXI_ARADDR_I <= a;
        S_AXI_ARVALID_I <= 1'h1;
        S_AXI_RREADY_I <= 1'h1;
        for (i = 0; i < 400; i++) begin
            @(negedge CLK_I);
            ta = S_AXI_ARVALID_I && S_AXI_ARREADY_O === 1'h1;
            tv = S_AXI_RVALID_O === 1'h1;
            d = S_AXI_RDATA_O;
            r = S_AXI_RRESP_O;
            @(posedge CLK_I);
            if (ta) S_AXI_ARVALID_I <= 1'h0;
            if (tv) break;
        end
        S_AXI_RREADY_I <= 1'h0;
        tmo(i);
    endtask
    // Standard request, then wait for the done or stall pulse
    task automatic rq(input logic [2:0] c, input logic [15:0] v, x, l,
                      input logic s);
        int i;
        logic ta, fin, st;
        @(posedge CLK_I);
        REQ_CODE_I <= c;
        REQ_VALUE_I <= v;
        REQ_INDEX_I <= x;
        REQ_LENGTH_I <= l;
        REQ_VALID_I <= 1'h1;
        clr <= 1'h1;
        for (i = 0; i < 400; i++) begin
            @(negedge CLK_I);
            ta = REQ_VALID_I && REQ_READY_O === 1'h1;
            st = STALL_O;
            fin = !REQ_VALID_I && (DONE_O || STALL_O) === 1'h1;
            @(posedge CLK_I);
            clr <= 1'h0;
            if (ta) REQ_VALID_I <= 1'h0;
            if (fin) break;
        end
        tmo(i);
        chk(st, s);
    endtask
    // Main sequence
    initial begin
        e = '{8'h09, 8'h02, 8'h0d, 8'h00, 8'h02, 8'h05, 8'h07, 8'he0,
            8'h4b, 8'h01, 8'h02, 8'h03, 8'h04};
        repeat (4) @(posedge CLK_I);
        RSTN_I <= 1'h1;
        wr(REG_CTRL, 32'h00000003);
        wr(REG_CFG, 32'h4b020705);
        wr(REG_TAIL_LEN, 32'h00000004);
        wr(TAIL_BASE, 32'h04030201);
        chk(r, RESP_OKAY);
        rd(REG_STATUS);
        chk(d, 32'h00000003);
        rd(12'h800);
        chk(r, RESP_SLVERR);
        wr(12'h800, 32'h00000000);
        chk(r, RESP_SLVERR);
        rq(REQ_SET_IF, 16'h0001, 16'h0000, 16'h0000, 1'h1);
        rq(REQ_GET_DESC, 16'h0200, 16'h0000, 16'h00ff, 1'h0);
        chk(n_rx, 13);
        for (k = 0; k < 13; k++)
            chk(rx[k], e[k]);
        chk({rx[3], rx[2]}, 16'h000d);
        chk(rx[8], 8'h4b);
        rq(REQ_GET_DESC, 16'h0200, 16'h0000, 16'h0003, 1'h0);
        chk(n_rx, 3);
        rq(REQ_GET_DESC, 16'h0100, 16'h0000, 16'h0009, 1'h1);
        rq(3'h7, 16'h0000, 16'h0000, 16'h0002, 1'h1);
        rq(REQ_SET_CFG, 16'h0003, 16'h0000, 16'h0000, 1'h1);
        rq(REQ_SET_CFG, 16'h0005, 16'h0000, 16'h0000, 1'h0);
        chk({CONFIGURED_O, CONFIG_VALUE_O}, 9'h105);
        chk(BUS_LIMIT_MA_O, 10'h096);
        rq(REQ_GET_CFG, 16'h0000, 16'h0000, 16'h0001, 1'h0);
        chk(rx[0], 8'h05);
        rq(REQ_SET_IF, 16'h0001, 16'h0000, 16'h0000, 1'h0);
        rq(REQ_SET_IF, 16'h0000, 16'h0002, 16'h0000, 1'h1);
        rq(REQ_GET_IF, 16'h0000, 16'h0000, 16'h0001, 1'h0);
        chk({CONFIGURED_O, rx[0]}, 9'h101);
        rq(REQ_GET_STATUS, 16'h0000, 16'h0000, 16'h0002, 1'h0);
        chk({rx[1], rx[0]}, 16'h0001);
        EXT_PWR_I <= 1'h0;
        repeat (4) @(posedge CLK_I);
        rq(REQ_GET_STATUS, 16'h0000, 16'h0000, 16'h0002, 1'h0);
        chk({rx[1], rx[0]}, 16'h0000);
        chk({LOW_POWER_O, OPS_FAIL_O, BUS_LIMIT_MA_O}, 12'hc96);
        rq(REQ_SET_IF, 16'h0000, 16'h0000, 16'h0000, 1'h1);
        wr(REG_CTRL, 32'h00000007);
        repeat (3) @(posedge CLK_I);
        chk(OPS_FAIL_O, 1'h0);
        rq(REQ_SET_IF, 16'h0000, 16'h0000, 16'h0000, 1'h0);
        rq(REQ_SET_CFG, 16'h0000, 16'h0000, 16'h0000, 1'h0);
        chk({CONFIGURED_O, CONFIG_VALUE_O}, 9'h000);
        chk(BUS_LIMIT_MA_O, 10'h064);
        final_report();
    end
endmodule
bind ucdr_top ucdr_checker #(.UNCFG_MA(UNCFG_MA)) chk_i (.CLK_I, .RSTN_I,
    .REQ_VALID_I, .REQ_READY_O, .REQ_CODE_I, .TX_VALID_O, .TX_READY_I,
    .TX_DATA_O, .TX_LAST_O, .DONE_O, .STALL_O, .CONFIGURED_O, .LOW_POWER_O,
    .BUS_LIMIT_MA_O, .OPS_FAIL_O);
